//--- shared/oag_defines.svh
// Notes on behaviour
// RULE1: Immediates decode as 2-bit selector, 4-bit, 8-bit, signed 8-bit and radix.
// RULE2: Soft vector is the 6-bit field, values 0 to 63, used directly.
// RULE3: Zero-page call target is the byte immediate, range 0000H to 00FFH.
// RULE4: Register direct access to 4-bit, 8-bit and 16-bit registers.
// RULE5: Indirect data address is the full first or second index register.
// RULE6: Post-increment forms add one to each selected index after transfer.
// RULE7: Short absolute counters and bit ops map to 0000H through 003FH.
// RULE8: Memory-relative branch adds the 4-bit word to the next address.
// RULE9: Short absolute I/O bit ops map field 0 to 3FH onto FFC0H-FFFFH.
// RULE10: Software takes care with bit ops on write-only or read-only I/O bits.
// RULE11: Relative jumps and call add signed byte offset to next address.
// RULE12: Jump by first data register offset, and jump to second index value.
// RULE13: Radix field selects the modulus for result and carry.
// RULE14: Writing the prefix register sets the extension pending flag.
// RULE15: Extension applies to the next instruction only, then the flag clears.
// RULE16: Extended index immediate forms use prefix high, operand low.
// RULE17: Software loads the complement of the high byte before extended compare.
// RULE18: Extended indirect goes to 0000H or FF00H plus prefix, index ignored.
// RULE19: Only non-incrementing indirect forms take the absolute extension.
// RULE20: Extended relative branches use a 16-bit offset, prefix high.
// RULE21: The data pair is second data register high, first data register low.
// RULE22: Interrupts wait until the extended instruction following has run.
// RULE23: Reset clears the extension pending flag.
`ifndef OAG_DEFINES_SVH
`define OAG_DEFINES_SVH
`define OAG_LOW_PAGE    16'h0000
`define OAG_IO_PAGE     16'hffc0
`define OAG_HIGH_PAGE   16'hff00
`define OAG_ONE16       16'h0001
`define OAG_ZERO16      16'h0000
`define OAG_RESET_EXT   1'b0
`endif

//--- shared/oag_pkg.sv
package oag_pkg;
  typedef enum logic [3:0] {
    OAG_M_NONE   = 4'h0,
    OAG_M_IND    = 4'h1,
    OAG_M_ABS_LO = 4'h2,
    OAG_M_ABS_IO = 4'h3,
    OAG_M_REL8   = 4'h4,
    OAG_M_RELMEM = 4'h5,
    OAG_M_RELA   = 4'h6,
    OAG_M_JPY    = 4'h7,
    OAG_M_ZCALL  = 4'h8,
    OAG_M_SOFTV  = 4'h9,
    OAG_M_IMM8X  = 4'ha
  } oag_mode_e;
  typedef enum logic [3:0] {
    OAG_R_A = 4'h0, OAG_R_B = 4'h1, OAG_R_F = 4'h2, OAG_R_BA = 4'h3,
    OAG_R_IDXH = 4'h4, OAG_R_IDXL = 4'h5, OAG_R_EXT = 4'h6,
    OAG_R_RSP = 4'h7, OAG_R_NSP = 4'h8, OAG_R_X = 4'h9, OAG_R_Y = 4'ha
  } oag_reg_e;
endpackage

//--- design/oag_radix.sv
`timescale 1ns/1ps
module oag_radix (
  // Operands.
  input  wire logic [3:0] a_in,
  input  wire logic [3:0] b_in,
  input  wire logic       carry_in,
  input  wire logic       sub_in,
  input  wire logic [3:0] radix_field,
  // Result.
  output logic      [3:0] sum_out,
  output logic            carry_out
);
  logic [4:0] modulus;
  logic [5:0] raw;
  // RULE13 radix modulus
  // Field value n selects modulus n plus one, so 15 means plain binary.
  always_comb begin
    modulus = {1'b0, radix_field} + 5'h01;
    if (sub_in) begin
      raw = {2'b00, a_in} - {2'b00, b_in} - {5'h00, carry_in};
      carry_out = raw[5];
      sum_out = raw[5] ? 4'(raw[3:0] + modulus[3:0]) : raw[3:0];
    end else begin
      raw = {2'b00, a_in} + {2'b00, b_in} + {5'h00, carry_in};
      carry_out = (raw >= {1'b0, modulus});
      sum_out = carry_out ? 4'(raw[3:0] - modulus[3:0]) : raw[3:0];
    end
  end
endmodule // oag_radix

//--- design/oag_core.sv
`timescale 1ns/1ps
`include "oag_defines.svh"
module oag_core (
  // Clock and reset.
  input  wire logic        CLK,
  input  wire logic        RESET,
  // Decoded instruction fields.
  input  wire logic        EXEC,
  input  wire logic [3:0]  MODE,
  input  wire logic        USE_Y,
  input  wire logic        USE_Y2,
  input  wire logic        POST_INC,
  input  wire logic        POST_INC2,
  input  wire logic        EXT_CAPABLE,
  input  wire logic [12:0] INSTR,
  input  wire logic [15:0] NEXT_PC,
  input  wire logic [3:0]  MEM_NIBBLE,
  // Register direct write.
  input  wire logic        REG_WE,
  input  wire logic [3:0]  REG_SEL,
  input  wire logic [15:0] REG_WDATA,
  // Radix arithmetic.
  input  wire logic        RADIX_SUB,
  input  wire logic        RADIX_CIN,
  input  wire logic [3:0]  RADIX_B,
  // Interrupt request.
  input  wire logic        IRQ_REQ,
  // Outputs.
  output logic      [15:0] DATA_ADDR,
  output logic      [15:0] DATA_ADDR2,
  output logic      [15:0] BRANCH_TARGET,
  output logic      [15:0] IMM16,
  output logic      [5:0]  SOFT_VECTOR,
  output logic      [1:0]  BIT_SEL,
  output logic      [3:0]  NIBBLE_IMM,
  output logic      [15:0] REG_RDATA,
  output logic      [3:0]  RADIX_SUM,
  output logic             RADIX_COUT,
  output logic             EXT_PENDING,
  output logic             IRQ_ACCEPT,
  output logic      [15:0] INDEX_X,
  output logic      [15:0] INDEX_Y
);
  logic [3:0]  a_reg, b_reg, f_reg;
  logic [7:0]  ext_reg, rsp_reg, nsp_reg;
  logic [15:0] x_reg, y_reg;
  logic        ext_flag_reg;
  logic [7:0]  byte_immediate, signed_byte_offset;
  logic [5:0]  short_absolute_field;
  logic        ext_active, ext_write, cout_w;
  logic [15:0] addr_next, addr2_next, target_next, imm_next, rdata_next;
  logic [3:0]  sum_w;

  // RULE1 field decode
  assign byte_immediate       = INSTR[7:0];
  assign signed_byte_offset   = INSTR[7:0];
  assign short_absolute_field = INSTR[5:0];
  // RULE19 extension eligibility
  assign ext_active = ext_flag_reg && EXT_CAPABLE && !POST_INC && !POST_INC2;
  assign ext_write  = REG_WE && (REG_SEL == oag_pkg::OAG_R_EXT);

  always_comb begin
    addr_next   = `OAG_ZERO16;
    addr2_next  = `OAG_ZERO16;
    target_next = NEXT_PC;
    imm_next    = {8'h00, byte_immediate};
    case (MODE)
      oag_pkg::OAG_M_IND: begin
        // RULE18 absolute extension
        if (ext_active)
          addr_next = USE_Y ? (`OAG_HIGH_PAGE | {8'h00, ext_reg})
                            : (`OAG_LOW_PAGE | {8'h00, ext_reg});
        // RULE5 index address
        else
          addr_next = USE_Y ? y_reg : x_reg;
        addr2_next = USE_Y2 ? y_reg : x_reg;
      end
      // RULE7 low page
      oag_pkg::OAG_M_ABS_LO:
        addr_next = `OAG_LOW_PAGE | {10'h000, short_absolute_field};
      // RULE9 io page
      oag_pkg::OAG_M_ABS_IO:
        addr_next = `OAG_IO_PAGE | {10'h000, short_absolute_field};
      oag_pkg::OAG_M_REL8: begin
        // RULE20 wide offset
        if (ext_flag_reg && EXT_CAPABLE)
          target_next = 16'(NEXT_PC + {ext_reg, signed_byte_offset});
        // RULE11 signed offset
        else
          target_next = 16'(NEXT_PC + {{8{signed_byte_offset[7]}},
                                       signed_byte_offset});
      end
      // RULE8 memory offset
      oag_pkg::OAG_M_RELMEM: begin
        addr_next   = `OAG_LOW_PAGE | {10'h000, short_absolute_field};
        target_next = 16'(NEXT_PC + {12'h000, MEM_NIBBLE});
      end
      // RULE12 register jumps
      oag_pkg::OAG_M_RELA: target_next = 16'(NEXT_PC + {12'h000, a_reg});
      oag_pkg::OAG_M_JPY:  target_next = y_reg;
      // RULE3 zero page call
      oag_pkg::OAG_M_ZCALL: target_next = {8'h00, byte_immediate};
      // RULE2 soft vector
      oag_pkg::OAG_M_SOFTV: target_next = {10'h000, INSTR[5:0]};
      // RULE16 wide immediate
      oag_pkg::OAG_M_IMM8X:
        if (ext_flag_reg && EXT_CAPABLE)
          imm_next = {ext_reg, byte_immediate};
        else
          imm_next = {{8{byte_immediate[7]}}, byte_immediate};
      default: addr_next = `OAG_ZERO16;
    endcase
  end

  // RULE4 register read
  always_comb begin
    if (REG_SEL == oag_pkg::OAG_R_A) rdata_next = {12'h000, a_reg};
    else if (REG_SEL == oag_pkg::OAG_R_B) rdata_next = {12'h000, b_reg};
    else if (REG_SEL == oag_pkg::OAG_R_F) rdata_next = {12'h000, f_reg};
    // RULE21 data pair
    else if (REG_SEL == oag_pkg::OAG_R_BA) rdata_next = {8'h00, b_reg, a_reg};
    else if (REG_SEL == oag_pkg::OAG_R_IDXH) rdata_next = {8'h00, x_reg[15:8]};
    else if (REG_SEL == oag_pkg::OAG_R_IDXL) rdata_next = {8'h00, x_reg[7:0]};
    else if (REG_SEL == oag_pkg::OAG_R_EXT) rdata_next = {8'h00, ext_reg};
    else if (REG_SEL == oag_pkg::OAG_R_RSP) rdata_next = {8'h00, rsp_reg};
    else if (REG_SEL == oag_pkg::OAG_R_NSP) rdata_next = {8'h00, nsp_reg};
    else if (REG_SEL == oag_pkg::OAG_R_X) rdata_next = x_reg;
    else if (REG_SEL == oag_pkg::OAG_R_Y) rdata_next = y_reg;
    else rdata_next = `OAG_ZERO16;
  end

  oag_radix oag_radix_inst (
    .a_in        (a_reg),
    .b_in        (RADIX_B),
    .carry_in    (RADIX_CIN),
    .sub_in      (RADIX_SUB),
    .radix_field (INSTR[3:0]),
    .sum_out     (sum_w),
    .carry_out   (cout_w)
  );

  // RULE4 register write
  always_ff @(posedge CLK) begin
    if (RESET) begin
      a_reg   <= 4'h0;
      b_reg   <= 4'h0;
      f_reg   <= 4'h0;
      ext_reg <= 8'h00;
      rsp_reg <= 8'h00;
      nsp_reg <= 8'h00;
    end else if (REG_WE) begin
      if (REG_SEL == oag_pkg::OAG_R_A) a_reg <= REG_WDATA[3:0];
      else if (REG_SEL == oag_pkg::OAG_R_B) b_reg <= REG_WDATA[3:0];
      else if (REG_SEL == oag_pkg::OAG_R_F) f_reg <= REG_WDATA[3:0];
      else if (REG_SEL == oag_pkg::OAG_R_BA) begin
        b_reg <= REG_WDATA[7:4];
        a_reg <= REG_WDATA[3:0];
      end
      else if (REG_SEL == oag_pkg::OAG_R_EXT) ext_reg <= REG_WDATA[7:0];
      else if (REG_SEL == oag_pkg::OAG_R_RSP) rsp_reg <= REG_WDATA[7:0];
      else if (REG_SEL == oag_pkg::OAG_R_NSP) nsp_reg <= REG_WDATA[7:0];
    end
  end

  // Index registers; a direct write wins over a post-increment.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      x_reg <= `OAG_ZERO16;
      y_reg <= `OAG_ZERO16;
    end else if (REG_WE && (REG_SEL == oag_pkg::OAG_R_X ||
                            REG_SEL == oag_pkg::OAG_R_IDXH ||
                            REG_SEL == oag_pkg::OAG_R_IDXL ||
                            REG_SEL == oag_pkg::OAG_R_Y)) begin
      if (REG_SEL == oag_pkg::OAG_R_X) x_reg <= REG_WDATA;
      else if (REG_SEL == oag_pkg::OAG_R_IDXH) x_reg[15:8] <= REG_WDATA[7:0];
      else if (REG_SEL == oag_pkg::OAG_R_IDXL) x_reg[7:0] <= REG_WDATA[7:0];
      else y_reg <= REG_WDATA;
    end else if (EXEC && MODE == oag_pkg::OAG_M_IND) begin
      // RULE6 post increment
      if ((POST_INC && !USE_Y) || (POST_INC2 && !USE_Y2))
        x_reg <= 16'(x_reg + `OAG_ONE16);
      if ((POST_INC && USE_Y) || (POST_INC2 && USE_Y2))
        y_reg <= 16'(y_reg + `OAG_ONE16);
    end
  end

  // Extension flag: a prefix write wins over consumption in the same cycle.
  always_ff @(posedge CLK) begin
    // RULE23 reset clear
    if (RESET)
      ext_flag_reg <= `OAG_RESET_EXT;
    // RULE14 set on write
    else if (ext_write)
      ext_flag_reg <= 1'b1;
    // RULE15 one shot
    else if (EXEC)
      ext_flag_reg <= 1'b0;
  end

  // Registered outputs.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      DATA_ADDR     <= `OAG_ZERO16;
      DATA_ADDR2    <= `OAG_ZERO16;
      BRANCH_TARGET <= `OAG_ZERO16;
      IMM16         <= `OAG_ZERO16;
      SOFT_VECTOR   <= 6'h00;
      BIT_SEL       <= 2'h0;
      NIBBLE_IMM    <= 4'h0;
      REG_RDATA     <= `OAG_ZERO16;
      RADIX_SUM     <= 4'h0;
      RADIX_COUT    <= 1'b0;
      IRQ_ACCEPT    <= 1'b0;
    end else begin
      DATA_ADDR     <= addr_next;
      DATA_ADDR2    <= addr2_next;
      BRANCH_TARGET <= target_next;
      IMM16         <= imm_next;
      SOFT_VECTOR   <= INSTR[5:0];
      BIT_SEL       <= INSTR[1:0];
      NIBBLE_IMM    <= INSTR[3:0];
      REG_RDATA     <= rdata_next;
      RADIX_SUM     <= sum_w;
      RADIX_COUT    <= cout_w;
      // RULE22 interrupt deferral
      IRQ_ACCEPT    <= IRQ_REQ && !ext_flag_reg && !ext_write;
    end
  end

  assign EXT_PENDING = ext_flag_reg;
  assign INDEX_X     = x_reg;
  assign INDEX_Y     = y_reg;

  property p_ext_set;
    @(posedge CLK) disable iff (RESET) ext_write |=> ext_flag_reg;
  endproperty
  a_ext_set: assert property (p_ext_set) else $error("flag not set"); // RULE14
  property p_ext_clr;
    @(posedge CLK) disable iff (RESET)
      (EXEC && !ext_write && ext_flag_reg) |=> !ext_flag_reg;
  endproperty
  a_ext_clr: assert property (p_ext_clr) else $error("flag kept"); // RULE15
  property p_low;
    @(posedge CLK) disable iff (RESET)
      (MODE == oag_pkg::OAG_M_ABS_LO) |=> DATA_ADDR[15:6] == 10'h000;
  endproperty
  a_low: assert property (p_low) else $error("low page wrong"); // RULE7
  property p_io;
    @(posedge CLK) disable iff (RESET)
      (MODE == oag_pkg::OAG_M_ABS_IO) |=> DATA_ADDR[15:6] == 10'h3ff;
  endproperty
  a_io: assert property (p_io) else $error("io page wrong"); // RULE9
  property p_zc;
    @(posedge CLK) disable iff (RESET)
      (MODE == oag_pkg::OAG_M_ZCALL)
        |=> BRANCH_TARGET == {8'h00, $past(INSTR[7:0])};
  endproperty
  a_zc: assert property (p_zc) else $error("zero call wrong"); // RULE3
  property p_irq;
    @(posedge CLK) disable iff (RESET) ext_flag_reg |=> !IRQ_ACCEPT;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not deferred"); // RULE22
  property p_ind;
    @(posedge CLK) disable iff (RESET)
      (MODE == oag_pkg::OAG_M_IND && !ext_flag_reg && !USE_Y)
        |=> DATA_ADDR == $past(x_reg);
  endproperty
  a_ind: assert property (p_ind) else $error("index address"); // RULE5
  property p_inc;
    @(posedge CLK) disable iff (RESET)
      (EXEC && MODE == oag_pkg::OAG_M_IND && POST_INC && !USE_Y && !REG_WE)
        |=> x_reg == 16'($past(x_reg) + `OAG_ONE16);
  endproperty
  a_inc: assert property (p_inc) else $error("post inc"); // RULE6
  property p_pair;
    @(posedge CLK) disable iff (RESET)
      (REG_SEL == oag_pkg::OAG_R_BA) |=> REG_RDATA[7:4] == $past(b_reg);
  endproperty
  a_pair: assert property (p_pair) else $error("pair order"); // RULE21
  c_ext: cover property (@(posedge CLK) ext_write ##[1:2] EXEC);
  c_rel: cover property (@(posedge CLK)
    MODE == oag_pkg::OAG_M_REL8 && ext_flag_reg);
  c_abs: cover property (@(posedge CLK)
    MODE == oag_pkg::OAG_M_IND && ext_active);
endmodule // oag_core

//--- tb/oag_mem_model.sv
`timescale 1ns/1ps
module oag_mem_model (
  // Word address inside the low data area.
  input  wire logic [5:0] word_addr,
  // Stored 4-bit word.
  output logic      [3:0] word_data
);
  // A fixed pattern stands in for RAM so the bench can predict every word.
  // low area word
  always_comb begin
    word_data = word_addr[3:0] ^ 4'ha;
  end
endmodule // oag_mem_model

//--- tb/test_operand_address_generation.sv
`timescale 1ns/1ps
module test_operand_address_generation;
  logic        clk = 1'b0;
  logic        rst, exec, use_y, use_y2, post_inc, post_inc2, ext_cap;
  logic        reg_we, radix_sub, radix_cin, irq_req;
  logic [3:0]  mode, mem_nib, reg_sel, radix_b;
  logic [12:0] instr;
  logic [15:0] next_pc, reg_wdata, data_addr, data_addr2, branch_target;
  logic [15:0] imm16, reg_rdata, index_x, index_y;
  logic [5:0]  soft_vec;
  logic [1:0]  bit_sel;
  logic [3:0]  nib_imm, radix_sum;
  logic        radix_cout, ext_pend, irq_acc;
  int          mismatches = 0;
  int          checked = 0;
  // Radix cases: second operand, field, subtract, carry in, sum, carry out.
  logic [3:0]  rb[3] = '{4'h8, 4'h8, 4'h3};
  logic [3:0]  rn[3] = '{4'h9, 4'hf, 4'h9};
  logic        rs[3] = '{1'b0, 1'b0, 1'b1};
  logic        rc[3] = '{1'b0, 1'b1, 1'b1};
  logic [3:0]  rsum[3] = '{4'h7, 4'h2, 4'h5};
  logic        rco[3] = '{1'b1, 1'b1, 1'b0};

  always #10 clk = ~clk;

  oag_core oag_core_inst (
    .CLK(clk), .RESET(rst), .EXEC(exec), .MODE(mode), .USE_Y(use_y),
    .USE_Y2(use_y2), .POST_INC(post_inc), .POST_INC2(post_inc2),
    .EXT_CAPABLE(ext_cap), .INSTR(instr), .NEXT_PC(next_pc),
    .MEM_NIBBLE(mem_nib), .REG_WE(reg_we), .REG_SEL(reg_sel),
    .REG_WDATA(reg_wdata), .RADIX_SUB(radix_sub), .RADIX_CIN(radix_cin),
    .RADIX_B(radix_b), .IRQ_REQ(irq_req), .DATA_ADDR(data_addr),
    .DATA_ADDR2(data_addr2), .BRANCH_TARGET(branch_target),
    .IMM16(imm16), .SOFT_VECTOR(soft_vec), .BIT_SEL(bit_sel),
    .NIBBLE_IMM(nib_imm), .REG_RDATA(reg_rdata), .RADIX_SUM(radix_sum),
    .RADIX_COUT(radix_cout), .EXT_PENDING(ext_pend), .IRQ_ACCEPT(irq_acc),
    .INDEX_X(index_x), .INDEX_Y(index_y));

  oag_mem_model oag_mem_model_inst (
    .word_addr(instr[5:0]),
    .word_data(mem_nib));

  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wreg(input logic [3:0] sel, input logic [15:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_sel <= sel;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
    #1;
  endtask

  task automatic rdreg(input logic [3:0] sel);
    @(posedge clk);
    reg_sel <= sel;
    @(posedge clk);
    #1;
  endtask

  // Both index operands are always set up; y2 selects the other index.
  task automatic issue(input logic [3:0] m, input logic [12:0] ins,
                       input logic uy, input logic pi, input logic ec,
                       input logic p2);
    @(posedge clk);
    mode <= m;
    instr <= ins;
    use_y <= uy;
    use_y2 <= ~uy;
    post_inc <= pi;
    post_inc2 <= p2;
    ext_cap <= ec;
    exec <= 1'b1;
    @(posedge clk);
    exec <= 1'b0;
    #1;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("run cut short by watchdog");
    final_report();
  end

  initial begin
    {rst, exec, use_y, use_y2, post_inc, post_inc2, ext_cap} = 7'h41;
    {reg_we, radix_sub, radix_cin, irq_req} = 4'h0;
    {mode, reg_sel, radix_b, instr} = 25'h0;
    {next_pc, reg_wdata} = 32'h0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("ext_pend", 16'(ext_pend), 16'h0000);
    issue(oag_pkg::OAG_M_IMM8X, 13'h1a9b, 0, 0, 0, 0);
    chk("bit_sel", 16'(bit_sel), 16'h0003);
    chk("nib_imm", 16'(nib_imm), 16'h000b);
    chk("imm16", imm16, 16'hff9b);
    issue(oag_pkg::OAG_M_SOFTV, 13'h1fff, 0, 0, 0, 0);
    chk("soft_vec", 16'(soft_vec), 16'h003f);
    chk("target", branch_target, 16'h003f);
    issue(oag_pkg::OAG_M_ZCALL, 13'h01ff, 0, 0, 0, 0);
    chk("target", branch_target, 16'h00ff);
    wreg(oag_pkg::OAG_R_A, 16'h0005);
    wreg(oag_pkg::OAG_R_B, 16'h000c);
    wreg(oag_pkg::OAG_R_X, 16'h1234);
    wreg(oag_pkg::OAG_R_Y, 16'hff80);
    rdreg(oag_pkg::OAG_R_BA);
    chk("pair", reg_rdata, 16'h00c5);
    rdreg(oag_pkg::OAG_R_IDXH);
    chk("x_high", reg_rdata, 16'h0012);
    chk("index_y", index_y, 16'hff80);
    issue(oag_pkg::OAG_M_IND, 13'h0000, 1, 0, 0, 0);
    chk("addr", data_addr, 16'hff80);
    issue(oag_pkg::OAG_M_IND, 13'h0000, 0, 1, 0, 1);
    chk("addr", data_addr, 16'h1234);
    chk("addr2", data_addr2, 16'hff80);
    chk("index_x", index_x, 16'h1235);
    chk("index_y", index_y, 16'hff81);
    issue(oag_pkg::OAG_M_ABS_LO, 13'h1fff, 0, 0, 0, 0);
    chk("addr", data_addr, 16'h003f);
    issue(oag_pkg::OAG_M_ABS_IO, 13'h0005, 0, 0, 0, 0);
    chk("addr", data_addr, 16'hffc5);
    @(posedge clk);
    next_pc <= 16'h1ffe;
    issue(oag_pkg::OAG_M_RELMEM, 13'h0025, 0, 0, 0, 0);
    chk("target", branch_target, 16'h200d);
    @(posedge clk);
    next_pc <= 16'h0100;
    issue(oag_pkg::OAG_M_REL8, 13'h007f, 0, 0, 0, 0);
    chk("target", branch_target, 16'h017f);
    issue(oag_pkg::OAG_M_REL8, 13'h0080, 0, 0, 0, 0);
    chk("target", branch_target, 16'h0080);
    issue(oag_pkg::OAG_M_RELA, 13'h0000, 0, 0, 0, 0);
    chk("target", branch_target, 16'h0105);
    issue(oag_pkg::OAG_M_JPY, 13'h0000, 0, 0, 0, 0);
    chk("target", branch_target, 16'hff81);
    wreg(oag_pkg::OAG_R_A, 16'h0009);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      radix_b <= rb[i];
      radix_sub <= rs[i];
      radix_cin <= rc[i];
      instr <= {9'h000, rn[i]};
      @(posedge clk);
      #1;
      chk("radix_sum", 16'(radix_sum), 16'(rsum[i]));
      chk("radix_cout", 16'(radix_cout), 16'(rco[i]));
    end
    wreg(oag_pkg::OAG_R_EXT, 16'h0037);
    chk("ext_pend", 16'(ext_pend), 16'h0001);
    issue(oag_pkg::OAG_M_IND, 13'h0000, 0, 0, 1, 0);
    chk("addr", data_addr, 16'h0037);
    chk("ext_pend", 16'(ext_pend), 16'h0000);
    issue(oag_pkg::OAG_M_IND, 13'h0000, 0, 0, 1, 0);
    chk("addr", data_addr, 16'h1235);
    wreg(oag_pkg::OAG_R_EXT, 16'h009c);
    issue(oag_pkg::OAG_M_IND, 13'h0000, 1, 0, 1, 0);
    chk("addr", data_addr, 16'hff9c);
    wreg(oag_pkg::OAG_R_EXT, 16'h0040);
    issue(oag_pkg::OAG_M_IND, 13'h0000, 0, 1, 1, 0);
    chk("addr", data_addr, 16'h1235);
    chk("index_x", index_x, 16'h1236);
    wreg(oag_pkg::OAG_R_EXT, 16'h0015);
    issue(oag_pkg::OAG_M_IMM8X, 13'h007d, 0, 0, 1, 0);
    chk("imm16", imm16, 16'h157d);
    wreg(oag_pkg::OAG_R_EXT, 16'h00e6);
    issue(oag_pkg::OAG_M_IMM8X, 13'h00a2, 0, 0, 1, 0);
    chk("imm16", imm16, 16'he6a2);
    wreg(oag_pkg::OAG_R_EXT, 16'h00f8);
    issue(oag_pkg::OAG_M_REL8, 13'h0062, 0, 0, 1, 0);
    chk("target", branch_target, 16'hf962);
    @(posedge clk);
    irq_req <= 1'b1;
    @(posedge clk);
    #1;
    chk("irq_acc", 16'(irq_acc), 16'h0001);
    wreg(oag_pkg::OAG_R_EXT, 16'h0011);
    chk("irq_acc", 16'(irq_acc), 16'h0000);
    issue(oag_pkg::OAG_M_IND, 13'h0000, 0, 0, 1, 0);
    chk("irq_acc", 16'(irq_acc), 16'h0000);
    @(posedge clk);
    #1;
    chk("irq_acc", 16'(irq_acc), 16'h0001);
    wreg(oag_pkg::OAG_R_EXT, 16'h0022);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("ext_pend", 16'(ext_pend), 16'h0000);
    final_report();
  end
endmodule // test_operand_address_generation
